// ### design/disp_pkg.sv
package disp_pkg;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_MHZ        = 50;
    localparam int PANEL_WAIT_MS  = 100;
    localparam int PANEL_WAIT_CYC = PANEL_WAIT_MS * 1000 * CLK_MHZ;
    localparam int RST_PULSE_US   = 10;
    localparam int RST_PULSE_CYC  = RST_PULSE_US * CLK_MHZ;
    localparam int SCLK_HALF_NS   = 60;
    localparam int SCLK_HALF_CYC  = (SCLK_HALF_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W          = 23;
    localparam int CLEAR_BYTES    = 1024;

    ////////////////////////////////////////////////////////////////////////
    // display commands
    localparam logic [7:0] CMD_DISP_OFF       = 8'hAE;
    localparam logic [7:0] CMD_DISP_ON        = 8'hAF;
    localparam logic [7:0] CMD_CONTRAST       = 8'h81;
    localparam logic [7:0] CMD_FOLLOW_MEM     = 8'hA4;
    localparam logic [7:0] CMD_ALL_ON         = 8'hA5;
    localparam logic [7:0] CMD_NORMAL         = 8'hA6;
    localparam logic [7:0] CMD_INVERT         = 8'hA7;
    localparam logic [7:0] CMD_SEG_NORM       = 8'hA0;
    localparam logic [7:0] CMD_SEG_REMAP      = 8'hA1;
    localparam logic [7:0] CMD_SCAN_NORM      = 8'hC0;
    localparam logic [7:0] CMD_SCAN_REV       = 8'hC8;
    localparam logic [1:0] CMD_START_TOP      = 2'h1;
    localparam logic [3:0] CMD_COL_LO_TOP     = 4'h0;
    localparam logic [3:0] CMD_COL_HI_TOP     = 4'h1;
    localparam logic [7:0] CLEAR_BYTE         = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // device reset values
    localparam logic [7:0] CONTRAST_RST   = 8'h7F;
    localparam logic [5:0] MUX_RST        = 6'h3F;
    localparam logic [5:0] START_LINE_RST = 6'h00;
    localparam logic [6:0] COL_RST        = 7'h00;

    ////////////////////////////////////////////////////////////////////////
    // controller registers
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CMD  = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;
    localparam int CTRL_UP_BIT   = 0;
    localparam int CTRL_DN_BIT   = 1;
    localparam int CTRL_RST_BIT  = 2;
    localparam int CMD_DC_BIT    = 8;
    localparam int ST_BUSY_BIT   = 0;
    localparam int ST_VDD_BIT    = 1;
    localparam int ST_VCC_BIT    = 2;
    localparam int ST_INIT_BIT   = 3;
    localparam int ST_ON_BIT     = 4;
    localparam int ST_PEND_BIT   = 5;
    localparam int ST_STATE_LSB  = 8;

    typedef enum logic [0:0] {
        DS_CMD      = 1'b0,
        DS_CONTRAST = 1'b1
    } dev_st_t;

    typedef enum logic [3:0] {
        HS_OFF     = 4'h0,
        HS_OFF_CMD = 4'h1,
        HS_RST     = 4'h3,
        HS_CLEAR   = 4'h2,
        HS_VCC     = 4'h6,
        HS_WAIT_UP = 4'h7,
        HS_ON_CMD  = 4'h5,
        HS_ON      = 4'h4,
        HS_DN_CMD  = 4'hC,
        HS_DN_VDD  = 4'hD,
        HS_DN_WAIT = 4'hF
    } host_st_t;

endpackage : disp_pkg

// ### design/disp_link_if.sv
`timescale 1ns/1ps
interface disp_link_if;
    logic init_low_n;
    logic sclk;
    logic sdin;
    logic cs_n;
    logic dc;
    logic vdd_en;
    logic vcc_en;

    modport host (
        output init_low_n,
        output sclk,
        output sdin,
        output cs_n,
        output dc,
        output vdd_en,
        output vcc_en
    );

    modport dev (
        input init_low_n,
        input sclk,
        input sdin,
        input cs_n,
        input dc,
        input vdd_en,
        input vcc_en
    );
endinterface : disp_link_if

// ### design/disp_dev.sv
`timescale 1ns/1ps
// Summary of operation
// RULE1: init low: display off, 128x64 mode
// RULE2: reset selects normal segment and row mapping
// RULE3: reset clears serial receive shift register
// RULE4: reset sets start line to zero
// RULE5: reset sets column counter to zero
// RULE6: reset selects normal common scan direction
// RULE7: reset loads contrast with 7Fh
// RULE8: reset selects follow-memory normal display mode
// RULE9: host: logic supply, off, init, clear, panel
// RULE10: host waits 100ms before display on
// RULE11: host: off, logic down, 100ms, panel down
// RULE12: host resets display to recover corruption
module disp_dev
    import disp_pkg::*;
(
    input  wire logic     CORE_CLK,
    input  wire logic     ARST_N,
    disp_link_if.dev      LINK,
    output logic          DISP_ON,
    output logic          PANEL_LIT,
    output logic [5:0]    MUX_ROWS,
    output logic          SEG_REMAP,
    output logic          COM_REVERSE,
    output logic [5:0]    START_LINE,
    output logic [6:0]    COL_ADDR,
    output logic [7:0]    CONTRAST,
    output logic          FOLLOW_MEM,
    output logic          INVERT,
    output logic          PIX_WE,
    output logic [7:0]    PIX_DATA,
    output logic [6:0]    PIX_COL
);

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic       init_s1;
        logic       init_s2;
        logic       vdd_s1;
        logic       vdd_s2;
        logic       vcc_s1;
        logic       vcc_s2;
        logic       sclk_s1;
        logic       sclk_s2;
        logic       sclk_d;
        logic       sdin_s1;
        logic       sdin_s2;
        logic       cs_s1;
        logic       cs_s2;
        logic       dc_s1;
        logic       dc_s2;
        logic [7:0] sh;
        logic [2:0] bits;
        dev_st_t    st;
        logic       disp_on;
        logic       panel_lit;
        logic [5:0] mux_rows;
        logic       seg_remap;
        logic       com_rev;
        logic [5:0] start_line;
        logic [6:0] col;
        logic [7:0] contrast;
        logic       follow_mem;
        logic       invert;
        logic       pix_we;
        logic [7:0] pix_data;
        logic [6:0] pix_col;
    } dev_t;

    localparam dev_t DEV_RST = '{
        st         : DS_CMD,
        cs_s1      : 1'b1,
        cs_s2      : 1'b1,
        mux_rows   : MUX_RST,
        contrast   : CONTRAST_RST,
        follow_mem : 1'b1,
        default    : '0
    };

    dev_t        r_r;
    dev_t        r_nxt;
    logic [7:0]  rx_byte;
    logic        in_rst;
    logic        sclk_rise;

    assign rx_byte   = {r_r.sh[6:0], r_r.sdin_s2};
    assign in_rst    = !r_r.init_s2 || !r_r.vdd_s2;
    assign sclk_rise = r_r.sclk_s2 && !r_r.sclk_d;

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        r_nxt = r_r;
        r_nxt.init_s1 = LINK.init_low_n;
        r_nxt.init_s2 = r_r.init_s1;
        r_nxt.vdd_s1  = LINK.vdd_en;
        r_nxt.vdd_s2  = r_r.vdd_s1;
        r_nxt.vcc_s1  = LINK.vcc_en;
        r_nxt.vcc_s2  = r_r.vcc_s1;
        r_nxt.sclk_s1 = LINK.sclk;
        r_nxt.sclk_s2 = r_r.sclk_s1;
        r_nxt.sclk_d  = r_r.sclk_s2;
        r_nxt.sdin_s1 = LINK.sdin;
        r_nxt.sdin_s2 = r_r.sdin_s1;
        r_nxt.cs_s1   = LINK.cs_n;
        r_nxt.cs_s2   = r_r.cs_s1;
        r_nxt.dc_s1   = LINK.dc;
        r_nxt.dc_s2   = r_r.dc_s1;
        r_nxt.pix_we  = 1'b0;
        r_nxt.panel_lit = r_r.disp_on && r_r.vcc_s2;

        if (in_rst) begin
            // held here for as long as the init line or the logic supply is low
            r_nxt.disp_on    = 1'b0;                    // [RULE1]
            r_nxt.mux_rows   = MUX_RST;                 // [RULE1]
            r_nxt.seg_remap  = 1'b0;                    // [RULE2]
            r_nxt.sh         = '0;                      // [RULE3]
            r_nxt.bits       = '0;                      // [RULE3]
            r_nxt.st         = DS_CMD;                  // [RULE3]
            r_nxt.start_line = START_LINE_RST;          // [RULE4]
            r_nxt.col        = COL_RST;                 // [RULE5]
            r_nxt.com_rev    = 1'b0;                    // [RULE6]
            r_nxt.contrast   = CONTRAST_RST;            // [RULE7]
            r_nxt.follow_mem = 1'b1;                    // [RULE8]
            r_nxt.invert     = 1'b0;                    // [RULE8]
        end else if (r_r.cs_s2) begin
            // deselect drops a partly shifted byte
            r_nxt.bits = '0;
        end else if (sclk_rise) begin
            r_nxt.sh   = rx_byte;
            r_nxt.bits = r_r.bits + 3'd1;
            if (r_r.bits == 3'd7) begin
                if (r_r.dc_s2) begin
                    r_nxt.pix_we   = 1'b1;
                    r_nxt.pix_data = rx_byte;
                    r_nxt.pix_col  = r_r.col;
                    r_nxt.col      = r_r.col + 7'd1;
                end else begin
                    case (r_r.st)
                        DS_CONTRAST: begin
                            r_nxt.contrast = rx_byte;
                            r_nxt.st       = DS_CMD;
                        end
                        DS_CMD: begin
                            case (rx_byte)
                                CMD_DISP_OFF: begin
                                    r_nxt.disp_on = 1'b0;
                                end
                                CMD_DISP_ON: begin
                                    r_nxt.disp_on = 1'b1;
                                end
                                CMD_CONTRAST: begin
                                    r_nxt.st = DS_CONTRAST;
                                end
                                CMD_FOLLOW_MEM: begin
                                    r_nxt.follow_mem = 1'b1;
                                end
                                CMD_ALL_ON: begin
                                    r_nxt.follow_mem = 1'b0;
                                end
                                CMD_NORMAL: begin
                                    r_nxt.invert = 1'b0;
                                end
                                CMD_INVERT: begin
                                    r_nxt.invert = 1'b1;
                                end
                                CMD_SEG_NORM: begin
                                    r_nxt.seg_remap = 1'b0;
                                end
                                CMD_SEG_REMAP: begin
                                    r_nxt.seg_remap = 1'b1;
                                end
                                CMD_SCAN_NORM: begin
                                    r_nxt.com_rev = 1'b0;
                                end
                                CMD_SCAN_REV: begin
                                    r_nxt.com_rev = 1'b1;
                                end
                                default: begin
                                    if (rx_byte[7:6] == CMD_START_TOP) begin
                                        r_nxt.start_line = rx_byte[5:0];
                                    end else if (rx_byte[7:4]
                                                 == CMD_COL_LO_TOP) begin
                                        r_nxt.col[3:0] = rx_byte[3:0];
                                    end else if (rx_byte[7:4]
                                                 == CMD_COL_HI_TOP) begin
                                        r_nxt.col[6:4] = rx_byte[2:0];
                                    end
                                end
                            endcase
                        end
                        default: begin
                            r_nxt.st = DS_CMD;
                        end
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            r_r <= DEV_RST;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign DISP_ON     = r_r.disp_on;
    assign PANEL_LIT   = r_r.panel_lit;
    assign MUX_ROWS    = r_r.mux_rows;
    assign SEG_REMAP   = r_r.seg_remap;
    assign COM_REVERSE = r_r.com_rev;
    assign START_LINE  = r_r.start_line;
    assign COL_ADDR    = r_r.col;
    assign CONTRAST    = r_r.contrast;
    assign FOLLOW_MEM  = r_r.follow_mem;
    assign INVERT      = r_r.invert;
    assign PIX_WE      = r_r.pix_we;
    assign PIX_DATA    = r_r.pix_data;
    assign PIX_COL     = r_r.pix_col;

endmodule : disp_dev

// ### design/disp_host.sv
`timescale 1ns/1ps
module disp_host
    import disp_pkg::*;
#(
    parameter int WAIT_CYC = PANEL_WAIT_CYC
)
(
    input  wire logic        CORE_CLK,
    input  wire logic        ARST_N,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic [31:0]      HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    disp_link_if.host        LINK
);

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        host_st_t         st;
        logic [CNT_W-1:0] cnt;
        logic [10:0]      clr;
        logic             recov;
        logic             vdd;
        logic             vcc;
        logic             init_n;
        logic             cs_n;
        logic             sclk;
        logic             sdin;
        logic             dc;
        logic             tx_act;
        logic [7:0]       tx_sh;
        logic [2:0]       tx_bit;
        logic [1:0]       tx_ph;
        logic [1:0]       tx_div;
        logic             cmd_pend;
        logic [8:0]       cmd_byte;
        logic             dp_wr;
        logic [7:0]       dp_addr;
        logic [31:0]      rdata;
        logic             hready;
    } host_t;

    localparam host_t HOST_RST = '{
        st      : HS_OFF,
        init_n  : 1'b1,
        cs_n    : 1'b1,
        hready  : 1'b1,
        default : '0
    };

    host_t       r_r;
    host_t       r_nxt;
    logic [31:0] stat;
    logic        acc;
    logic        wr_ctrl;
    logic        wr_cmd;

    function automatic host_t tx_start(host_t s, logic [7:0] b, logic d);
        host_t t;
        t        = s;
        t.tx_act = 1'b1;
        t.cs_n   = 1'b0;
        t.sclk   = 1'b0;
        t.dc     = d;
        t.tx_sh  = b;
        t.sdin   = b[7];
        t.tx_bit = '0;
        t.tx_ph  = '0;
        t.tx_div = '0;
        return t;
    endfunction : tx_start

    assign acc     = HSEL && HTRANS[1] && HREADY;
    assign wr_ctrl = r_r.dp_wr && (r_r.dp_addr == REG_CTRL);
    assign wr_cmd  = r_r.dp_wr && (r_r.dp_addr == REG_CMD);

    always_comb begin
        stat = '0;
        stat[ST_BUSY_BIT] = r_r.tx_act || r_r.cmd_pend ||
                            (r_r.st != HS_ON && r_r.st != HS_OFF);
        stat[ST_VDD_BIT]  = r_r.vdd;
        stat[ST_VCC_BIT]  = r_r.vcc;
        stat[ST_INIT_BIT] = !r_r.init_n;
        stat[ST_ON_BIT]   = (r_r.st == HS_ON);
        stat[ST_PEND_BIT] = r_r.cmd_pend;
        stat[ST_STATE_LSB +: 4] = r_r.st;
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        r_nxt = r_r;
        // bus slave: zero wait, data phase follows address phase
        r_nxt.dp_wr   = acc && HWRITE;
        r_nxt.dp_addr = HADDR[7:0];
        r_nxt.rdata   = (acc && !HWRITE && HADDR[7:0] == REG_STAT) ?
                        stat : '0;
        if (wr_cmd && r_r.st == HS_ON && !r_r.cmd_pend) begin
            r_nxt.cmd_pend = 1'b1;
            r_nxt.cmd_byte = HWDATA[CMD_DC_BIT:0];
        end

        // serial byte engine, msb first, device samples on rising sclk
        if (r_r.tx_act) begin
            if (r_r.tx_div != 2'(SCLK_HALF_CYC - 1)) begin
                r_nxt.tx_div = r_r.tx_div + 2'd1;
            end else begin
                r_nxt.tx_div = '0;
                case (r_r.tx_ph)
                    2'd0: begin
                        r_nxt.sclk  = 1'b1;
                        r_nxt.tx_ph = 2'd1;
                    end
                    2'd1: begin
                        r_nxt.sclk = 1'b0;
                        if (r_r.tx_bit == 3'd7) begin
                            r_nxt.cs_n  = 1'b1;
                            r_nxt.tx_ph = 2'd2;
                        end else begin
                            r_nxt.tx_bit = r_r.tx_bit + 3'd1;
                            r_nxt.tx_sh  = {r_r.tx_sh[6:0], 1'b0};
                            r_nxt.sdin   = r_r.tx_sh[6];
                            r_nxt.tx_ph  = 2'd0;
                        end
                    end
                    default: begin
                        r_nxt.tx_act = 1'b0;
                    end
                endcase
            end
        end

        case (r_r.st)
            HS_OFF: begin
                if (wr_ctrl && HWDATA[CTRL_UP_BIT]) begin
                    r_nxt.vdd = 1'b1;                          // [RULE9]
                    r_nxt.st  = HS_OFF_CMD;
                end
            end
            HS_OFF_CMD: begin
                if (!r_r.tx_act) begin
                    r_nxt    = tx_start(r_nxt, CMD_DISP_OFF, 1'b0); // [RULE9]
                    r_nxt.st = HS_RST;
                end
            end
            HS_RST: begin
                if (r_r.tx_act) begin
                    r_nxt.cnt = '0;
                end else if (r_r.init_n) begin
                    r_nxt.init_n = 1'b0;                       // [RULE9]
                    r_nxt.cnt    = '0;
                end else if (r_r.cnt == CNT_W'(RST_PULSE_CYC - 1)) begin
                    r_nxt.init_n = 1'b1;
                    r_nxt.cnt    = '0;
                    r_nxt.recov  = 1'b0;
                    r_nxt.st     = r_r.recov ? HS_ON_CMD : HS_CLEAR;
                end else begin
                    r_nxt.cnt = r_r.cnt + CNT_W'(1);
                end
            end
            HS_CLEAR: begin
                if (!r_r.tx_act) begin
                    r_nxt     = tx_start(r_nxt, CLEAR_BYTE, 1'b1); // [RULE9]
                    r_nxt.clr = r_r.clr + 11'd1;
                    if (r_r.clr == 11'(CLEAR_BYTES - 1)) begin
                        r_nxt.clr = '0;
                        r_nxt.st  = HS_VCC;
                    end
                end
            end
            HS_VCC: begin
                if (!r_r.tx_act) begin
                    r_nxt.vcc = 1'b1;                          // [RULE9]
                    r_nxt.cnt = '0;
                    r_nxt.st  = HS_WAIT_UP;
                end
            end
            HS_WAIT_UP: begin
                if (r_r.cnt == CNT_W'(WAIT_CYC - 1)) begin     // [RULE10]
                    r_nxt.st = HS_ON_CMD;
                end else begin
                    r_nxt.cnt = r_r.cnt + CNT_W'(1);
                end
            end
            HS_ON_CMD: begin
                if (!r_r.tx_act) begin
                    r_nxt    = tx_start(r_nxt, CMD_DISP_ON, 1'b0); // [RULE10]
                    r_nxt.st = HS_ON;
                end
            end
            HS_ON: begin
                if (wr_ctrl && HWDATA[CTRL_DN_BIT]) begin
                    r_nxt.cmd_pend = 1'b0;
                    r_nxt.st       = HS_DN_CMD;
                end else if (wr_ctrl && HWDATA[CTRL_RST_BIT]) begin
                    r_nxt.cmd_pend = 1'b0;                     // [RULE12]
                    r_nxt.recov    = 1'b1;
                    r_nxt.st       = HS_RST;
                end else if (r_r.cmd_pend && !r_r.tx_act) begin
                    r_nxt = tx_start(r_nxt, r_r.cmd_byte[7:0],
                                     r_r.cmd_byte[CMD_DC_BIT]);
                    r_nxt.cmd_pend = 1'b0;
                end
            end
            HS_DN_CMD: begin
                if (!r_r.tx_act) begin
                    r_nxt    = tx_start(r_nxt, CMD_DISP_OFF, 1'b0); // [RULE11]
                    r_nxt.st = HS_DN_VDD;
                end
            end
            HS_DN_VDD: begin
                if (!r_r.tx_act) begin
                    r_nxt.vdd = 1'b0;                          // [RULE11]
                    r_nxt.cnt = '0;
                    r_nxt.st  = HS_DN_WAIT;
                end
            end
            HS_DN_WAIT: begin
                if (r_r.cnt == CNT_W'(WAIT_CYC - 1)) begin     // [RULE11]
                    r_nxt.vcc = 1'b0;
                    r_nxt.st  = HS_OFF;
                end else begin
                    r_nxt.cnt = r_r.cnt + CNT_W'(1);
                end
            end
            default: begin
                r_nxt.st = HS_OFF;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            r_r <= HOST_RST;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign HRDATA          = r_r.rdata;
    assign HREADYOUT       = r_r.hready;
    assign HRESP           = 1'b0 & r_r.hready;
    assign LINK.init_low_n = r_r.init_n;
    assign LINK.sclk       = r_r.sclk;
    assign LINK.sdin       = r_r.sdin;
    assign LINK.cs_n       = r_r.cs_n;
    assign LINK.dc         = r_r.dc;
    assign LINK.vdd_en     = r_r.vdd;
    assign LINK.vcc_en     = r_r.vcc;

endmodule : disp_host

// ### tb/disp_link_sva.sv
`timescale 1ns/1ps
module disp_link_sva #(
    parameter int WAIT_CYC = 200
) (
    input wire logic CORE_CLK,
    input wire logic ARST_N,
    input wire logic init_low_n,
    input wire logic sclk,
    input wire logic sdin,
    input wire logic cs_n,
    input wire logic vdd_en,
    input wire logic vcc_en
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!ARST_N);
    logic [31:0] on_r;
    logic [31:0] off_r;
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            on_r  <= '0;
            off_r <= '0;
        end else begin
            on_r  <= vcc_en ? on_r + 32'h1 : '0;
            off_r <= vdd_en ? '0 : off_r + 32'h1;
        end
    end
    ////////////////////////////////////////
    sequence s_byte_end;
        $rose(cs_n);
    endsequence
    sequence s_init_start;
        $fell(init_low_n);
    endsequence
    chk_cs_gap: assert property (s_byte_end |-> cs_n [*3])
        else $error("chip select gap too short");
    chk_init_pulse:
        assert property (s_init_start |-> !init_low_n [*8])
        else $error("init pulse too short");
    chk_sclk_idle: assert property (cs_n |-> !sclk)
        else $error("serial clock moved while deselected");
    chk_sdin_hold: assert property (sclk |-> $stable(sdin))
        else $error("serial data moved while clock high");
    chk_up_order: assert property ($rose(vdd_en) |-> !vcc_en)
        else $error("panel supply on before logic supply");
    chk_vcc_after_init:
        assert property ($rose(vcc_en) |-> vdd_en && init_low_n)
        else $error("panel supply on too early");
    chk_on_wait:
        assert property ($fell(cs_n) && vcc_en |-> on_r >= WAIT_CYC - 2)
        else $error("byte sent during panel settle wait");
    chk_down_wait:
        assert property ($fell(vcc_en) |-> !vdd_en && off_r >= WAIT_CYC - 2)
        else $error("panel supply off too early");
endmodule : disp_link_sva

// ### tb/oled_reset_power_sequence_tb_top.sv
`timescale 1ns/1ps
module oled_reset_power_sequence_tb_top;
    import disp_pkg::*;
    localparam int WAIT = 200;
    logic        core_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0]  htrans = '0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    logic [31:0] hrdata;
    logic        hready;
    logic        disp_on, panel_lit, seg_rmp, com_rev, follow, invert;
    logic        pix_we;
    logic [5:0]  mux_rows, start_line;
    logic [6:0]  col_addr;
    logic [7:0]  contrast, pix_data;
    int          n_mismatch = 0;
    int          compares = 0;
    int          cyc = 0;
    int          n_pix = 0;
    disp_link_if lnk ();
    always #10 core_clk = ~core_clk;
    disp_host #(.WAIT_CYC(WAIT)) u_disp_host (.CORE_CLK(core_clk),
        .ARST_N(arst_n), .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
        .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(), .LINK(lnk.host));
    disp_dev u_disp_dev (.CORE_CLK(core_clk), .ARST_N(arst_n),
        .LINK(lnk.dev), .DISP_ON(disp_on), .PANEL_LIT(panel_lit),
        .MUX_ROWS(mux_rows), .SEG_REMAP(seg_rmp), .COM_REVERSE(com_rev),
        .START_LINE(start_line), .COL_ADDR(col_addr), .CONTRAST(contrast),
        .FOLLOW_MEM(follow), .INVERT(invert), .PIX_WE(pix_we),
        .PIX_DATA(pix_data), .PIX_COL());
    disp_link_sva #(.WAIT_CYC(WAIT)) u_disp_link_sva (.CORE_CLK(core_clk),
        .ARST_N(arst_n), .init_low_n(lnk.init_low_n), .sclk(lnk.sclk),
        .sdin(lnk.sdin), .cs_n(lnk.cs_n), .vdd_en(lnk.vdd_en),
        .vcc_en(lnk.vcc_en));
    ////////////////////////////////////////
    task end_of_test;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    always @(posedge core_clk) begin
        cyc++;
        if (pix_we && pix_data == CLEAR_BYTE) n_pix++;
        if (cyc == 90000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] q);
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        @(posedge core_clk);
        while (hready !== 1'b1) @(posedge core_clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge core_clk);
        while (hready !== 1'b1) @(posedge core_clk);
        q = hrdata;
    endtask : ahb
    task wait_bit(input int b, input logic v);
        logic [31:0] q;
        do ahb(1'b0, REG_STAT, '0, q); while (q[b] !== v);
    endtask : wait_bit
    task chk_map;
        chk("mux", 32'(MUX_RST), 32'(mux_rows));
        chk("seg", 32'h0, 32'(seg_rmp));
        chk("com", 32'h0, 32'(com_rev));
        chk("start", 32'h0, 32'(start_line));
        chk("col", 32'h0, 32'(col_addr));
        chk("contrast", 32'(CONTRAST_RST), 32'(contrast));
        chk("follow", 32'h1, 32'(follow));
        chk("invert", 32'h0, 32'(invert));
    endtask : chk_map
    ////////////////////////////////////////
    task t_reset;
        chk_map();
        chk("disp_on", 32'h0, 32'(disp_on));
    endtask : t_reset
    task t_up;
        logic [31:0] q;
        ahb(1'b1, REG_CTRL, 32'h1, q);
        wait_bit(ST_ON_BIT, 1'b1);
        repeat (54) @(posedge core_clk);
        ahb(1'b0, REG_STAT, '0, q);
        chk("supplies", 32'h3, 32'(q[ST_VCC_BIT:ST_VDD_BIT]));
        chk("lit", 32'h1, 32'({disp_on, panel_lit} == 2'b11));
        chk_map();
        chk("clear", 32'(CLEAR_BYTES), 32'(n_pix));
    endtask : t_up
    task t_recover;
        logic [31:0] q;
        logic [7:0]  cmds [6];
        cmds = '{8'h81, 8'h33, CMD_SCAN_REV, CMD_SEG_REMAP, CMD_ALL_ON, 8'h45};
        foreach (cmds[i]) begin
            wait_bit(ST_PEND_BIT, 1'b0);
            ahb(1'b1, REG_CMD, {24'h0, cmds[i]}, q);
        end
        wait_bit(ST_PEND_BIT, 1'b0);
        repeat (54) @(posedge core_clk);
        chk("changed", 32'h0000_335C, 32'({contrast, 1'b0, start_line[2:0],
            com_rev, seg_rmp, 1'b0, follow}));
        ahb(1'b1, REG_CTRL, 32'h4, q);
        wait_bit(ST_INIT_BIT, 1'b1);
        repeat (10) @(posedge core_clk);
        chk("held_off", 32'h0, 32'(disp_on));
        chk_map();
        wait_bit(ST_INIT_BIT, 1'b0);
        wait_bit(ST_PEND_BIT, 1'b0);
        repeat (60) @(posedge core_clk);
        chk("back_on", 32'h1, 32'(disp_on));
    endtask : t_recover
    task t_down;
        logic [31:0] q;
        ahb(1'b1, REG_CTRL, 32'h2, q);
        wait_bit(ST_VCC_BIT, 1'b0);
        ahb(1'b0, REG_STAT, '0, q);
        chk("off_vdd", 32'h0, 32'({disp_on, q[ST_VDD_BIT]}));
    endtask : t_down
    initial begin
        repeat (8) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        t_reset();
        t_up();
        t_recover();
        t_down();
        end_of_test();
    end
endmodule : oled_reset_power_sequence_tb_top
